// ### rtl/pps_in_sync.sv
/*
 pps_in_sync: three-flop input synchroniser with agreement filter.
 Assumes inputs come from pins outside the mclk_in domain.
*/
`timescale 1ns/100ps
`default_nettype none
module pps_in_sync #(
	parameter int         W       = 16,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input  wire logic         mclk_in,  // system clock
	input  wire logic         rst_b_in, // async reset, active low
	input  wire logic [W-1:0] d_in,     // raw pin levels
	output logic      [W-1:0] q_out     // filtered levels
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;

	// shift chain; first stage feeds only the second
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ff1_r <= RST_VAL;
			ff2_r <= RST_VAL;
			ff3_r <= RST_VAL;
		end else begin
			ff1_r <= d_in;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
		end
	end

	// a bit changes once stages two and three agree
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			q_out <= RST_VAL;
		end else begin
			q_out <= (ff2_r & ff3_r) | (q_out & (ff2_r | ff3_r));
		end
	end
endmodule
`default_nettype wire

// ### rtl/pps_pin_mux.sv
/*
 pps_pin_mux: combinational function selector for one pin.
 Assumes code 0 is gpio and codes 1..3 index the alternates.
*/
`timescale 1ns/100ps
`default_nettype none
module pps_pin_mux (
	input  wire logic [1:0] code_in,    // selected function code
	input  wire logic [3:0] valid_in,   // defined codes
	input  wire logic [3:0] analog_in,  // analog codes
	input  wire logic       out_only_in,// pin is output only
	input  wire logic       gpio_out_in,// gpio output level
	input  wire logic       gpio_dir_in,// gpio direction, 1 drives
	input  wire logic [2:0] alt_out_in, // alternate output levels
	input  wire logic [2:0] alt_oe_in,  // alternate drive requests
	input  wire logic       pad_lvl_in, // synchronised pin level
	output logic            drv_out,    // level to drive
	output logic            oe_out,     // 1 while pin is driven
	output logic            ana_out,    // analog switch on
	output logic      [2:0] alt_in_out  // pin level per alternate
);
	logic [1:0] idx;

	// route by code; undefined codes leave the pin floating
	always_comb begin
		idx        = code_in - 2'h1;
		drv_out    = 1'b0;
		oe_out     = 1'b0;
		ana_out    = 1'b0;
		alt_in_out = 3'h0;
		if (valid_in[code_in]) begin
			if (code_in == 2'h0) begin
				drv_out = gpio_out_in;
				oe_out  = gpio_dir_in | out_only_in;
			end else if (analog_in[code_in]) begin
				ana_out = 1'b1;
			end else begin
				drv_out         = alt_out_in[idx];
				oe_out          = alt_oe_in[idx];
				alt_in_out[idx] = pad_lvl_in;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/pps_top.sv
/*
 pps_top: pin function select for port-0 pins 16..31 and the
 debug and trace pin groups of port-1 pins 16..31.
 Assumes a single-cycle register port with read data one cycle
 later, peripherals that supply output level and drive request
 per alternate function, and pad cells with active-low enables.
*/
// Our own choice: the plain strobed port.
// What this block does
// - Each two-bit field of the upper port-0 select register picks one port-0 pin's function and resets to code 0, which is gpio on every pin but 0.24.
// - A port-0 pin other than 0.24 and 0.31 obeys its direction bit only under gpio; under a digital alternate the peripheral sets direction.
// - Pin 0.16 gives gpio, external interrupt 0, timer 0 match 2 or timer 0 capture 2 for codes 0 to 3.
// - Pin 0.17 gives capture 1.2, serial clock or match 1.2; pin 0.20 gives match 1.3, serial select or interrupt 3.
// - Pin 0.18 gives capture 1.3, serial data in or match 1.3; pin 0.19 gives match 1.2, serial data out or capture 1.2.
// - Pin 0.21 gives pwm 5, second adc input 6 or capture 1.3; pin 0.22 gives second adc input 7, capture 0.0 or match 0.0.
// - Pin 0.27 gives first adc input 0, capture 0.1 or match 0.1; pin 0.28 gives adc input 1, capture 0.2 or match 0.2.
// - Pin 0.29 gives adc input 2, capture 0.3 or match 0.3; pin 0.30 gives adc input 3, interrupt 3 or capture 0.0.
// - Port-1 select bit 2 gives the debug pin group to gpio at 0 and to the debug port at 1.
// - Port-1 select bit 3 gives port-1 pins 25 to 16 to gpio at 0 and to the trace port at 1.
// - The debug select bit resets to 1 when the debug clock return pin is pulled low, else to 0.
// - The trace select bit resets to 1 when the trace sync pin is pulled low, else to 0.
// - Software writes no ones to port-1 select bits 1:0 and 31:4, whose read value is undefined.
// - A port-1 pin obeys its direction bit only under gpio; otherwise debug or trace sets direction.
`timescale 1ns/100ps
`default_nettype none
module pps_top #(
	parameter int STRAP_SETTLE = pps_pkg::STRAP_SETTLE_CY
) (
	input  wire logic                 mclk_in,               // 250 MHz clock
	input  wire logic                 rst_b_in,              // async reset, active low
	input  wire pps_pkg::pps_bus_req_t bus_req_in,           // register request
	output logic [31:0]               rd_data_out,           // read data, cycle after read
	input  wire logic [15:0]          p0_pad_in,             // port-0 pins 16..31 level
	output logic [15:0]               p0_pad_out,            // port-0 drive level
	output logic [15:0]               p0_pad_oe_b_out,       // port-0 enable, low drives
	output logic [15:0]               p0_analog_en_out,      // port-0 analog switch
	input  wire logic [15:0]          p0_gpio_out_in,        // port-0 gpio output bits
	input  wire logic [15:0]          port0_direction_reg_in,// port-0 direction bits
	output logic [15:0]               p0_gpio_in_out,        // port-0 pin levels
	input  wire logic [47:0]          p0_alt_out_in,         // alternate levels, 3 per pin
	input  wire logic [47:0]          p0_alt_oe_in,          // alternate drive requests
	output logic [47:0]               p0_alt_in_out,         // pin level to alternates
	input  wire logic [15:0]          p1_pad_in,             // port-1 pins 16..31 level
	output logic [15:0]               p1_pad_out,            // port-1 drive level
	output logic [15:0]               p1_pad_oe_b_out,       // port-1 enable, low drives
	input  wire logic [15:0]          p1_gpio_out_in,        // port-1 gpio output bits
	input  wire logic [15:0]          port1_direction_reg_in,// port-1 direction bits
	output logic [15:0]               p1_gpio_in_out,        // port-1 pin levels
	input  wire logic [15:0]          p1_func_out_in,        // debug or trace levels
	input  wire logic [15:0]          p1_func_oe_in,         // debug or trace drive
	output logic [15:0]               p1_func_in_out,        // pin level to debug or trace
	output logic                      debug_port_en_out,     // debug group selected
	output logic                      trace_port_en_out,     // trace group selected
	output logic                      strap_done_out         // straps taken
);
	localparam int NP = pps_pkg::PIN_CNT;
	localparam int NA = pps_pkg::ALT_CNT;

	// the filtered level is only valid one edge after the three stages fill,
	// so a shorter settle would load the pull-up reset value as the strap
	if (STRAP_SETTLE < pps_pkg::SYNC_DEPTH + 1 || STRAP_SETTLE >= (1 << pps_pkg::SETTLE_W)) begin : g_chk
		$error("pps_top: STRAP_SETTLE out of range");
	end

	localparam logic [pps_pkg::SETTLE_W-1:0] SETTLE_END = pps_pkg::SETTLE_W'(STRAP_SETTLE);

	// register state
	logic [31:0] sel0_r;
	logic        dbg_sel_r;
	logic        trace_sel_r;
	logic        strap_done_r;
	logic [pps_pkg::SETTLE_W-1:0] settle_r;

	// decoded access
	logic        hit_sel0;
	logic        hit_p1;
	logic [31:0] rd_nxt;

	// synchronised pin levels
	logic [NP-1:0] p0_lvl;
	logic [NP-1:0] p1_lvl;

	// combinational mux results
	logic [NP-1:0]    p0_drv;
	logic [NP-1:0]    p0_oe;
	logic [NP-1:0]    p0_ana;
	logic [NP*NA-1:0] p0_alt_in;
	logic [NP-1:0]    p1_drv;
	logic [NP-1:0]    p1_oe;
	logic [NP-1:0]    p1_fin;
	logic [NP-1:0]    p1_grp_sel;
	logic [2*NP-1:0]  p1_fin_unused; // unused alternate inputs of port-1 muxes

	// pin input synchronisers; idle level high models the pull-up
	pps_in_sync #(
		.W       (NP),
		.RST_VAL ('1)
	) u_p0_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     (p0_pad_in),
		.q_out    (p0_lvl)
	);

	pps_in_sync #(
		.W       (NP),
		.RST_VAL ('1)
	) u_p1_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     (p1_pad_in),
		.q_out    (p1_lvl)
	);

	// address decode
	always_comb begin
		hit_sel0 = 1'b0;
		hit_p1   = 1'b0;
		if (bus_req_in.addr == pps_pkg::SEL0_UPPER_ADDR) begin
			hit_sel0 = 1'b1;
		end else if (bus_req_in.addr == pps_pkg::P1_SEL_ADDR) begin
			hit_p1 = 1'b1;
		end
	end

	// upper port-0 select register, plain read/write
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sel0_r <= pps_pkg::SEL0_UPPER_RST;
		end else if (bus_req_in.wr && hit_sel0) begin
			sel0_r <= bus_req_in.wdata;
		end
	end

	// settle counter: waits for the synchroniser after reset release
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			settle_r     <= '0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			if (settle_r == SETTLE_END) begin
				strap_done_r <= 1'b1;
			end else begin
				settle_r <= settle_r + 1'b1;
			end
		end
	end

	// port-1 select bits: strap load once, then software writes
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dbg_sel_r   <= 1'b0;
			trace_sel_r <= 1'b0;
		end else if (!strap_done_r) begin
			if (settle_r == SETTLE_END) begin
				dbg_sel_r   <= ~p1_lvl[pps_pkg::DBG_STRAP];
				trace_sel_r <= ~p1_lvl[pps_pkg::TRACE_STRAP];
			end
		end else if (bus_req_in.wr && hit_p1) begin
			// reserved bits 1:0 and 31:4 are not stored
			dbg_sel_r   <= bus_req_in.wdata[pps_pkg::DBG_SEL_BIT];
			trace_sel_r <= bus_req_in.wdata[pps_pkg::TRACE_SEL_BIT];
		end
	end

	// read data; reserved and unmapped bits read as zero
	always_comb begin
		rd_nxt = 32'h0;
		if (bus_req_in.rd) begin
			if (hit_sel0) begin
				rd_nxt = sel0_r;
			end else if (hit_p1) begin
				rd_nxt[pps_pkg::DBG_SEL_BIT]   = dbg_sel_r;
				rd_nxt[pps_pkg::TRACE_SEL_BIT] = trace_sel_r;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_out <= 32'h0;
		end else begin
			rd_data_out <= rd_nxt;
		end
	end

	// port-0 function muxes, one per pin
	for (genvar i = 0; i < NP; i++) begin : g_p0
		pps_pin_mux u_mux (
			.code_in     (sel0_r[2*i +: 2]),
			.valid_in    (pps_pkg::P0_CODE_VALID[4*i +: 4]),
			.analog_in   (pps_pkg::P0_CODE_ANALOG[4*i +: 4]),
			.out_only_in (pps_pkg::P0_OUT_ONLY[i]),
			.gpio_out_in (p0_gpio_out_in[i]),
			.gpio_dir_in (port0_direction_reg_in[i]),
			.alt_out_in  (p0_alt_out_in[NA*i +: NA]),
			.alt_oe_in   (p0_alt_oe_in[NA*i +: NA]),
			.pad_lvl_in  (p0_lvl[i]),
			.drv_out     (p0_drv[i]),
			.oe_out      (p0_oe[i]),
			.ana_out     (p0_ana[i]),
			.alt_in_out  (p0_alt_in[NA*i +: NA])
		);
	end

	// port-1 group select per pin: trace group low, debug group high
	for (genvar j = 0; j < NP; j++) begin : g_p1
		if (j >= pps_pkg::TRACE_PIN_LO && j <= pps_pkg::TRACE_PIN_HI) begin : g_tr
			assign p1_grp_sel[j] = trace_sel_r;
		end else begin : g_db
			assign p1_grp_sel[j] = dbg_sel_r;
		end

		pps_pin_mux u_mux (
			.code_in     ({1'b0, p1_grp_sel[j]}),
			.valid_in    (pps_pkg::P1_CODE_VALID),
			.analog_in   (pps_pkg::NO_ANALOG),
			.out_only_in (1'b0),
			.gpio_out_in (p1_gpio_out_in[j]),
			.gpio_dir_in (port1_direction_reg_in[j]),
			.alt_out_in  ({2'b00, p1_func_out_in[j]}),
			.alt_oe_in   ({2'b00, p1_func_oe_in[j]}),
			.pad_lvl_in  (p1_lvl[j]),
			.drv_out     (p1_drv[j]),
			.oe_out      (p1_oe[j]),
			.ana_out     (),
			.alt_in_out  ({p1_fin_unused[2*j +: 2], p1_fin[j]})
		);
	end

	// port-0 pad registers; enable low while driving
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			p0_pad_out       <= 16'h0;
			p0_pad_oe_b_out  <= 16'hffff;
			p0_analog_en_out <= 16'h0;
		end else begin
			p0_pad_out       <= p0_drv;
			p0_pad_oe_b_out  <= ~p0_oe;
			p0_analog_en_out <= p0_ana;
		end
	end

	// port-0 levels toward gpio and the selected peripheral
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			p0_gpio_in_out <= 16'h0;
			p0_alt_in_out  <= 48'h0;
		end else begin
			p0_gpio_in_out <= p0_lvl;
			p0_alt_in_out  <= p0_alt_in;
		end
	end

	// port-1 pad registers
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			p1_pad_out      <= 16'h0;
			p1_pad_oe_b_out <= 16'hffff;
		end else begin
			p1_pad_out      <= p1_drv;
			p1_pad_oe_b_out <= ~p1_oe;
		end
	end

	// port-1 levels toward gpio and debug or trace
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			p1_gpio_in_out <= 16'h0;
			p1_func_in_out <= 16'h0;
		end else begin
			p1_gpio_in_out <= p1_lvl;
			p1_func_in_out <= p1_fin;
		end
	end

	// group enables and strap status for the debug and trace logic
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			debug_port_en_out <= 1'b0;
			trace_port_en_out <= 1'b0;
			strap_done_out    <= 1'b0;
		end else begin
			debug_port_en_out <= dbg_sel_r;
			trace_port_en_out <= trace_sel_r;
			strap_done_out    <= strap_done_r;
		end
	end
endmodule
`default_nettype wire

// ### shared/pps_pkg.sv
/*
 pps_pkg: constants and types shared by the pin function select block.
 Assumes a 32-bit byte-addressed register port and 16 upper port-0 pins.
*/
`default_nettype none
package pps_pkg;
	// register byte addresses
	localparam logic [31:0] SEL0_UPPER_ADDR = 32'he002c004;
	localparam logic [31:0] P1_SEL_ADDR     = 32'he002c014;
	localparam logic [31:0] SEL0_UPPER_RST  = 32'h00000000;

	// port-1 select register field positions
	localparam int DBG_SEL_BIT   = 2;
	localparam int TRACE_SEL_BIT = 3;

	// pin geometry: port-0 pins 16..31, port-1 pins 16..31
	localparam int PIN_CNT      = 16;
	localparam int ALT_CNT      = 3;
	localparam int CODE_W       = 2;
	localparam int TRACE_PIN_LO = 0;  // port-1 pin 16
	localparam int TRACE_PIN_HI = 9;  // port-1 pin 25
	localparam int TRACE_STRAP  = 4;  // port-1 pin 20, trace sync pin
	localparam int DBG_STRAP    = 10; // port-1 pin 26, debug clock return

	// per pin nibble: bit n set when code n is a defined function
	localparam logic [63:0] P0_CODE_VALID  = 64'h1ffff3701fffffff;
	// per pin nibble: bit n set when code n is an analog function
	localparam logic [63:0] P0_CODE_ANALOG = 64'h0222226002400000;
	// port-0 pin 31 drives under gpio whatever its direction bit says
	localparam logic [15:0] P0_OUT_ONLY    = 16'h8000;

	// port-1 pins know code 0 (gpio) and code 1 (debug or trace)
	localparam logic [3:0]  P1_CODE_VALID  = 4'h3;
	localparam logic [3:0]  NO_ANALOG      = 4'h0;

	// cycles after reset release before straps are taken
	localparam int SYNC_DEPTH      = 3;
	localparam int STRAP_SETTLE_CY = 4;
	localparam int SETTLE_W        = 4;

	// register port request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pps_bus_req_t;
endpackage
`default_nettype wire

// ### verification/pps_checker.sv
/*
 pps_checker: port-level assertions for the pin function select block.
 Assumes it is bound into pps_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module pps_checker #(
	parameter int STRAP_SETTLE = 4
) (
	input wire logic                  mclk_in,                // clock
	input wire logic                  rst_b_in,               // reset, active low
	input wire pps_pkg::pps_bus_req_t bus_req_in,             // register request
	input wire logic [31:0]           rd_data_out,            // read data
	input wire logic [15:0]           p0_pad_out,             // port-0 drive level
	input wire logic [15:0]           p0_pad_oe_b_out,        // port-0 enable, low drives
	input wire logic [15:0]           p0_analog_en_out,       // port-0 analog switch
	input wire logic [15:0]           port0_direction_reg_in, // port-0 direction
	input wire logic [47:0]           p0_alt_out_in,          // alternate levels
	input wire logic [47:0]           p0_alt_oe_in,           // alternate drive requests
	input wire logic [15:0]           p1_pad_in,              // port-1 pin levels
	input wire logic [15:0]           p1_pad_oe_b_out,        // port-1 enable, low drives
	input wire logic [15:0]           port1_direction_reg_in, // port-1 direction
	input wire logic [15:0]           p1_func_oe_in,          // debug or trace drive
	input wire logic                  debug_port_en_out,      // debug group on
	input wire logic                  trace_port_en_out,      // trace group on
	input wire logic                  strap_done_out          // straps taken
);
	logic [31:0] sel0_r; // shadow of the upper port-0 select register
	logic [7:0]  cnt_r;  // edges since reset release
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);
	// shadow of register writes and an edge counter
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sel0_r <= 32'h0;
			cnt_r  <= 8'h0;
		end else begin
			if (bus_req_in.wr && bus_req_in.addr == pps_pkg::SEL0_UPPER_ADDR)
				sel0_r <= bus_req_in.wdata;
			if (cnt_r != 8'hff)
				cnt_r <= cnt_r + 8'h1;
		end
	end
	a_read_idle_zero: assert property (!$past(bus_req_in.rd) |-> rd_data_out == 32'h0)
		else $error("read data outside the read slot");
	a_p1_reserved_zero: assert property (bus_req_in.rd && bus_req_in.addr == pps_pkg::P1_SEL_ADDR
		|=> rd_data_out[31:4] == 28'h0 && rd_data_out[1:0] == 2'h0) else $error("reserved bits read set");
	a_gpio_dir_pin16: assert property ($past(rst_b_in) && $past(sel0_r[1:0]) == 2'h0
		|-> p0_pad_oe_b_out[0] == !$past(port0_direction_reg_in[0])) else $error("gpio direction ignored");
	a_out_only_31: assert property ($past(rst_b_in) && $past(sel0_r[31:30]) == 2'h0
		|-> !p0_pad_oe_b_out[15]) else $error("output-only pin not driven");
	a_alt_drive_pin16: assert property ($past(rst_b_in) && $past(sel0_r[1:0]) == 2'h1
		|-> p0_pad_oe_b_out[0] == !$past(p0_alt_oe_in[0])
		&& (p0_pad_oe_b_out[0] || p0_pad_out[0] == $past(p0_alt_out_in[0]))) else $error("alternate drive wrong");
	a_analog_pin27: assert property ($past(rst_b_in) && $past(sel0_r[23:22]) == 2'h1
		|-> p0_analog_en_out[11] && p0_pad_oe_b_out[11]) else $error("analog code mishandled");
	a_pin24_undriven: assert property (p0_pad_oe_b_out[8])
		else $error("pin without function driven");
	a_p1_write_follow: assert property (bus_req_in.wr && bus_req_in.addr == pps_pkg::P1_SEL_ADDR && strap_done_out
		|-> ##2 debug_port_en_out == $past(bus_req_in.wdata[2], 2)
		&& trace_port_en_out == $past(bus_req_in.wdata[3], 2)) else $error("group enable does not follow write");
	a_strap_time: assert property ($rose(strap_done_out) |-> cnt_r == STRAP_SETTLE + 2)
		else $error("strap taken at wrong edge");
	a_strap_value: assert property ($rose(strap_done_out) |-> debug_port_en_out == !p1_pad_in[10]
		&& trace_port_en_out == !p1_pad_in[4]) else $error("strap level not inverted into select");
	a_p1_group_dir: assert property ($past(rst_b_in) |->
		p1_pad_oe_b_out[10] == (debug_port_en_out ? !$past(p1_func_oe_in[10]) : !$past(port1_direction_reg_in[10]))
		&& p1_pad_oe_b_out[4] == (trace_port_en_out ? !$past(p1_func_oe_in[4]) : !$past(port1_direction_reg_in[4])))
		else $error("port-1 direction source wrong");
	c_sel0_write: cover property (bus_req_in.wr && bus_req_in.addr == pps_pkg::SEL0_UPPER_ADDR);
	c_p1_write: cover property (bus_req_in.wr && bus_req_in.addr == pps_pkg::P1_SEL_ADDR && strap_done_out);
	c_strap: cover property ($rose(strap_done_out));
endmodule
`default_nettype wire

// ### verification/tb_top.sv
/*
 tb_top: directed bench for the pin function select block.
 Assumes pps_top, pps_pkg and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
	localparam int          SETTLE = 4;
	localparam logic [63:0] VALID  = 64'h1ffff3701fffffff; // defined codes, nibble per pin
	localparam logic [63:0] ANALOG = 64'h0222226002400000; // analog codes, nibble per pin
	logic [15:0]           p0_pad   = 16'ha5c3;
	logic                  mclk_in  = 1'b0;
	logic                  rst_b_in = 1'b0;
	pps_pkg::pps_bus_req_t req      = '0;
	logic [31:0]           rd_data_out;
	logic [15:0]           p0_pad_out, p0_oe_b, p0_ana, p0_gin, p1_pad_out, p1_oe_b, p1_gin, p1_fin;
	logic [15:0]           p0_gout = 16'h0, p0_dir = 16'h0, p1_pad = 16'hfbff, p1_gout = 16'h0;
	logic [15:0]           p1_dir = 16'h0, p1_fout = 16'h0, p1_foe = 16'h0;
	logic [47:0]           p0_ain, p0_dac_output = 48'h0, p0_aoe = 48'h0;
	logic                  dbg_en, trc_en, strap_done;
	int                    errors = 0, check_count = 0;
	// 250 MHz clock
	always #2 mclk_in = ~mclk_in;
	pps_top #(.STRAP_SETTLE(SETTLE)) pps_top_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus_req_in(req),
		.rd_data_out(rd_data_out), .p0_pad_in(p0_pad), .p0_pad_out(p0_pad_out), .p0_pad_oe_b_out(p0_oe_b),
		.p0_analog_en_out(p0_ana), .p0_gpio_out_in(p0_gout), .port0_direction_reg_in(p0_dir),
		.p0_gpio_in_out(p0_gin), .p0_alt_out_in(p0_dac_output), .p0_alt_oe_in(p0_aoe), .p0_alt_in_out(p0_ain),
		.p1_pad_in(p1_pad), .p1_pad_out(p1_pad_out), .p1_pad_oe_b_out(p1_oe_b), .p1_gpio_out_in(p1_gout),
		.port1_direction_reg_in(p1_dir), .p1_gpio_in_out(p1_gin), .p1_func_out_in(p1_fout),
		.p1_func_oe_in(p1_foe), .p1_func_in_out(p1_fin), .debug_port_en_out(dbg_en),
		.trace_port_en_out(trc_en), .strap_done_out(strap_done));
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr32(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_in);
		req.wr <= 1'b0;
	endtask
	// read data stands in the cycle after the strobe only
	task automatic rd32(input logic [31:0] a, input logic [31:0] e);
		@(posedge mclk_in);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_in);
		req.rd <= 1'b0;
		#1;
		`CHK(rd_data_out, e)
	endtask
	// reset with the given port-1 strap levels, then wait for the straps
	task automatic do_reset(input logic [15:0] pad);
		@(posedge mclk_in);
		rst_b_in <= 1'b0;
		p1_pad <= pad;
		repeat (6) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 40 && strap_done !== 1'b1; i++) @(posedge mclk_in);
		`CHK(strap_done, 1'b1)
	endtask
	// expected port-0 pin behaviour from the function tables
	task automatic chk_p0(input logic [31:0] sel);
		logic [1:0] c;
		logic       eoe, ean, eout;
		logic [2:0] ealt;
		int         x;
		for (int q = 0; q < 16; q++) begin
			c = sel[2*q +: 2];
			x = 3 * q + c - 1;
			eoe = 1'b1;
			ean = 1'b0;
			eout = 1'b0;
			ealt = 3'h0;
			if (c == 2'h0 && VALID[4*q]) begin
				eoe = (q == 15) ? 1'b0 : !p0_dir[q];
				eout = p0_gout[q];
			end else if (ANALOG[4*q+c]) begin
				ean = 1'b1;
			end else if (VALID[4*q+c]) begin
				eoe = !p0_aoe[x];
				eout = p0_dac_output[x];
				ealt[c-1] = p0_pad[q];
			end
			`CHK(p0_oe_b[q], eoe)
			`CHK(p0_ana[q], ean)
			`CHK(p0_pad_out[q] | p0_oe_b[q], eout | eoe)
			`CHK(p0_ain[3*q +: 3], ealt)
		end
		`CHK(p0_gin, p0_pad)
	endtask
	// expected port-1 pin behaviour for the two group selects
	task automatic chk_p1(input logic dbg, input logic trc);
		logic [15:0] grp, eoe;
		grp = {{6{dbg}}, {10{trc}}};
		eoe = ~((grp & p1_foe) | (~grp & p1_dir));
		`CHK(dbg_en, dbg)
		`CHK(trc_en, trc)
		`CHK(p1_oe_b, eoe)
		`CHK(p1_pad_out | p1_oe_b, (grp & p1_fout) | (~grp & p1_gout) | eoe)
		`CHK(p1_fin, grp & p1_pad)
		`CHK(p1_gin, p1_pad)
	endtask
	// main sequence
	initial begin
		logic [31:0] sel;
		do_reset(16'hfbff);
		rd32(pps_pkg::SEL0_UPPER_ADDR, pps_pkg::SEL0_UPPER_RST);
		rd32(pps_pkg::P1_SEL_ADDR, 32'h4);
		@(posedge mclk_in);
		p1_dir <= 16'hf0f0;
		p1_foe <= 16'h0ff0;
		p1_fout <= 16'h3355;
		p1_gout <= 16'hc3a5;
		// nonzero read data must be gone one cycle later
		#1;
		`CHK(rd_data_out, 32'h0)
		rd32(32'he002c008, 32'h0);
		chk_p1(1'b1, 1'b0);
		wr32(pps_pkg::P1_SEL_ADDR, 32'h4 | 32'h8);
		rd32(pps_pkg::P1_SEL_ADDR, 32'hc);
		chk_p1(1'b1, 1'b1);
		wr32(32'he002c008, 32'hffffffff);
		rd32(32'he002c008, 32'h0);
		// both strap pins high: both groups stay gpio, no select bit is cleared by software
		do_reset(16'hffff);
		rd32(pps_pkg::P1_SEL_ADDR, 32'h0);
		chk_p1(1'b0, 1'b0);
		for (int pass = 0; pass < 2; pass++) begin
			@(posedge mclk_in);
			p0_dir <= 16'h5a0f ^ {16{pass[0]}};
			p0_gout <= 16'h96c3 ^ {16{pass[0]}};
			p0_aoe <= 48'h0f0f3c3ca5a5 ^ {48{pass[0]}};
			p0_dac_output <= 48'h3333cccc6969 ^ {48{pass[0]}};
			p0_pad <= 16'ha5c3 ^ {16{pass[0]}};
			// let the new pin levels pass the input filter
			repeat (5) @(posedge mclk_in);
			for (int p = 0; p < 16; p++) begin
				for (int c = 0; c < 4; c++) begin
					sel = ({16{2'(3 - c)}} & ~(32'h3 << (2 * p))) | 32'(c << (2 * p));
					wr32(pps_pkg::SEL0_UPPER_ADDR, sel);
					rd32(pps_pkg::SEL0_UPPER_ADDR, sel);
					chk_p0(sel);
				end
			end
		end
		do_reset(16'hffef);
		rd32(pps_pkg::P1_SEL_ADDR, 32'h8);
		chk_p1(1'b0, 1'b1);
		test_done();
	end
	// watchdog against a hang
	initial begin
		#(4 * 20000);
		errors++;
		test_done();
	end
endmodule
bind pps_top pps_checker #(.STRAP_SETTLE(STRAP_SETTLE)) pps_checker_inst (.mclk_in, .rst_b_in, .bus_req_in,
	.rd_data_out, .p0_pad_out, .p0_pad_oe_b_out, .p0_analog_en_out, .port0_direction_reg_in, .p0_alt_out_in,
	.p0_alt_oe_in, .p1_pad_in, .p1_pad_oe_b_out, .port1_direction_reg_in, .p1_func_oe_in, .debug_port_en_out,
	.trace_port_en_out, .strap_done_out);
`default_nettype wire
